// >>> design/pbt_pkg.sv
// Constants, register map and state type of the error rate checker.
// Assumes a 50 MHz aclk and a 32-bit AXI4-Lite master.
// Operation
// - Fill shift register one length, then feedback.
// - Compare each bit with prediction, count mismatches.
// - Two 32-bit counters: checked bits, errored bits.
// - Stop when checked bits reach programmed maximum.
// - Stop when errors reach maximum, whichever first.
// - Record which limit ended the measurement.
// - Manual stop command halts counting any time.
// - Ninth-degree maximal sequence, period 511 bits.
// - Uninterrupted mode uses only data and clock.
// - Restart input suspends compare, resynchronises sequence.
// - Counts accumulate across restarts, cleared only at measurement start.
// - Bits outside data enable neither compared nor counted.
// - Optionally drop constant runs of 32 or more.
// - Dropped run also drops the preceding bit.
// - Report clock activity, data activity, synchronisation.
// - Error rate is errors over checked bits.
// - One enable switches measurement on or off.
// - Continuous auto-restart or single shot on trigger.
package pbt_pkg;

  // Clock and link timing
  localparam int CLK_MHZ     = 50;
  localparam int ACT_TIME_NS = 10000;
  localparam int ACT_CYCLES  = ACT_TIME_NS * CLK_MHZ / 1000;
  localparam int ACT_W       = 10;

  // Ninth-degree sequence, x^9 + x^5 + 1
  localparam int PRBS_DEG    = 9;
  localparam int PRBS_TAP    = 5;
  localparam int PRBS_PERIOD = (1 << PRBS_DEG) - 1;
  localparam int FILL_W      = 4;

  // Constant-run filter
  localparam int RUN_LEN   = 32;
  localparam int RUN_DEPTH = RUN_LEN + 1;
  localparam int RUN_CW    = 6;

  // Link pin order inside the sampler
  localparam int LNK_CLK = 0;
  localparam int LNK_DAT = 1;
  localparam int LNK_DE  = 2;
  localparam int LNK_RST = 3;
  localparam int LNK_N   = 4;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CMD    = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_BITS   = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_ERRS   = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_MAXB   = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_MAXE   = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_RBITS  = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_RERRS  = 8'h20;

  // Control fields
  localparam int CTRL_W      = 7;
  localparam int CTRL_EN     = 0;
  localparam int CTRL_SINGLE = 1;
  localparam int CTRL_RST_EN = 2;
  localparam int CTRL_DE_EN  = 3;
  localparam int CTRL_IGNORE = 4;
  localparam int CTRL_NEG    = 5;
  localparam int CTRL_INV    = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;

  // Command fields, write-only pulses
  localparam int CMD_EXEC = 0;
  localparam int CMD_STOP = 1;

  // Status fields
  localparam int ST_W       = 9;
  localparam int ST_RUNNING = 0;
  localparam int ST_T_BITS  = 1;
  localparam int ST_T_ERRS  = 2;
  localparam int ST_T_MAN   = 3;
  localparam int ST_T_SAT   = 4;
  localparam int ST_CLK_ACT = 5;
  localparam int ST_DAT_ACT = 6;
  localparam int ST_SYNC    = 7;
  localparam int ST_DONE    = 8;

  localparam logic [31:0] MAXB_RESET = 32'h0098_9680;
  localparam logic [31:0] MAXE_RESET = 32'h0000_0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    PBT_IDLE = 4'b0001,
    PBT_FILL = 4'b0010,
    PBT_RUN  = 4'b0100,
    PBT_DONE = 4'b1000
  } pbt_state_t;

endpackage

// >>> design/pbt_link_sampler.sv
// Link pin sampler: synchronises the bit clock, data, data enable and
// restart pins and finds the active bit clock edge on aclk.
// Assumes the bit clock runs at most a quarter of aclk.
`timescale 1ns/1ps
module pbt_link_sampler import pbt_pkg::*; (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Configuration
  input  wire logic slope_neg,
  // Link pins
  input  wire logic link_clk,
  input  wire logic link_data,
  input  wire logic link_de,
  input  wire logic link_restart,
  // Sampled bit
  output logic      bit_stb,
  output logic      bit_data,
  output logic      bit_de,
  output logic      bit_restart,
  // Activity pulses
  output logic      clk_edge,
  output logic      data_edge
);
  logic [LNK_N-1:0] raw;
  logic [LNK_N-1:0] meta;
  logic [LNK_N-1:0] sync;
  logic             clk_prev;
  logic             data_prev;
  logic             act_edge;

  assign raw = {link_restart, link_de, link_data, link_clk};

  generate
    for (genvar i = 0; i < LNK_N; i++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta[i] <= 1'b0;
          sync[i] <= 1'b0;
        end else begin
          meta[i] <= raw[i];
          sync[i] <= meta[i];
        end
      end
    end
  endgenerate

  // Data goes through the same two stages as the clock, so the
  // edge and the bit it qualifies stay aligned
  assign act_edge = slope_neg ? (clk_prev & ~sync[LNK_CLK])
                              : (~clk_prev & sync[LNK_CLK]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev    <= 1'b0;
      data_prev   <= 1'b0;
      bit_stb     <= 1'b0;
      bit_data    <= 1'b0;
      bit_de      <= 1'b0;
      bit_restart <= 1'b0;
      clk_edge    <= 1'b0;
      data_edge   <= 1'b0;
    end else begin
      clk_prev    <= sync[LNK_CLK];
      data_prev   <= sync[LNK_DAT];
      bit_stb     <= act_edge;
      bit_data    <= sync[LNK_DAT];
      bit_de      <= sync[LNK_DE];
      bit_restart <= sync[LNK_RST];
      clk_edge    <= clk_prev ^ sync[LNK_CLK];
      data_edge   <= data_prev ^ sync[LNK_DAT];
    end
  end

endmodule

// >>> design/pbt_run_filter.sv
// Constant-run filter: delays checked bits by one run length plus one
// and drops any run of identical bits that reaches the run length.
// Assumes one checked bit at most per aclk cycle.
`timescale 1ns/1ps
module pbt_run_filter import pbt_pkg::*; (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic clear,
  input  wire logic ignore_en,
  // Checked bits in
  input  wire logic in_stb,
  input  wire logic in_bit,
  input  wire logic in_err,
  // Bits to count
  output logic      out_stb,
  output logic      out_err
);
  logic [RUN_DEPTH-1:0] keep_line;
  logic [RUN_DEPTH-1:0] err_line;
  logic [RUN_CW-1:0]    run_cnt;
  logic [RUN_CW-1:0]    next_run;
  logic                 last_bit;
  logic                 run_hit;

  always_comb begin
    if (in_bit != last_bit || run_cnt == '0)
      next_run = RUN_CW'(1);
    else if (run_cnt == RUN_CW'(RUN_LEN))
      next_run = run_cnt;
    else
      next_run = run_cnt + RUN_CW'(1);
  end

  assign run_hit = (next_run == RUN_CW'(RUN_LEN));

  // Empty line slots hold keep=0, so they never leave as counted bits
  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !ignore_en) begin
      keep_line <= '0;
      err_line  <= '0;
      run_cnt   <= '0;
      last_bit  <= 1'b0;
    end else if (in_stb) begin
      run_cnt  <= next_run;
      last_bit <= in_bit;
      err_line <= {err_line[RUN_DEPTH-2:0], in_err};
      // Kills the run so far and the bit just before it
      if (run_hit)
        keep_line <= '0;
      else
        keep_line <= {keep_line[RUN_DEPTH-2:0], 1'b1};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      out_stb <= 1'b0;
      out_err <= 1'b0;
    end else if (!ignore_en) begin
      out_stb <= in_stb;
      out_err <= in_err;
    end else begin
      out_stb <= in_stb && keep_line[RUN_DEPTH-1];
      out_err <= err_line[RUN_DEPTH-1];
    end
  end

endmodule

// >>> design/pbt_error_rate_checker.sv
// Error rate checker top: AXI4-Lite registers, sequence sync,
// bit comparison, counting and stop logic.
// Assumes link pins asynchronous to aclk and one AXI4-Lite master.
`timescale 1ns/1ps
module pbt_error_rate_checker import pbt_pkg::*; (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Link pins from the device under test
  input  wire logic              link_clk,
  input  wire logic              link_data,
  input  wire logic              link_de,
  input  wire logic              link_restart
);
  logic [ADDR_W-1:0]   aw_addr;
  logic                aw_got;
  logic [31:0]         w_data;
  logic [3:0]          w_strb;
  logic                w_got;
  logic                wr_fire;
  logic                wr_hit;
  logic [31:0]         rd_data;
  logic                rd_hit;
  logic [CTRL_W-1:0]   ctrl;
  logic [31:0]         max_bits;
  logic [31:0]         max_errs;
  logic                exec_pulse;
  logic                stop_pulse;
  pbt_state_t          state;
  logic [FILL_W-1:0]   fill_cnt;
  logic [PRBS_DEG-1:0] lfsr;
  logic                bit_stb;
  logic                bit_data;
  logic                bit_de;
  logic                bit_restart;
  logic                clk_edge;
  logic                data_edge;
  logic                rx;
  logic                pred;
  logic                bit_use;
  logic                bit_rst;
  logic                chk_stb;
  logic                chk_bit;
  logic                chk_err;
  logic                flt_stb;
  logic                flt_err;
  logic [31:0]         bits;
  logic [31:0]         errs;
  logic [31:0]         next_bits;
  logic [31:0]         next_errs;
  logic [31:0]         res_bits;
  logic [31:0]         res_errs;
  logic                active;
  logic                hit_bits;
  logic                hit_errs;
  logic                hit_sat;
  logic                start;
  logic                stop;
  logic                term_bits;
  logic                term_errs;
  logic                term_man;
  logic                term_sat;
  logic [ACT_W-1:0]    clk_timer;
  logic [ACT_W-1:0]    dat_timer;
  logic [ST_W-1:0]     status;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = new_v[8*i +: 8];
    return res;
  endfunction

  // AXI4-Lite write address and data, taken in either order
  assign wr_fire = aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got        <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got        <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    unique case (aw_addr)
      ADDR_CTRL, ADDR_CMD, ADDR_STATUS, ADDR_BITS, ADDR_ERRS,
      ADDR_MAXB, ADDR_MAXE, ADDR_RBITS, ADDR_RERRS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers; read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl       <= CTRL_RESET;
      max_bits   <= MAXB_RESET;
      max_errs   <= MAXE_RESET;
      exec_pulse <= 1'b0;
      stop_pulse <= 1'b0;
    end else begin
      exec_pulse <= 1'b0;
      stop_pulse <= 1'b0;
      if (wr_fire) begin
        if (aw_addr == ADDR_CTRL && w_strb[0])
          ctrl <= w_data[CTRL_W-1:0];
        if (aw_addr == ADDR_MAXB)
          max_bits <= merge(max_bits, w_data, w_strb);
        if (aw_addr == ADDR_MAXE)
          max_errs <= merge(max_errs, w_data, w_strb);
        if (aw_addr == ADDR_CMD && w_strb[0]) begin
          exec_pulse <= w_data[CMD_EXEC];
          stop_pulse <= w_data[CMD_STOP];
        end
      end
    end
  end

  // AXI4-Lite read
  assign status = {state == PBT_DONE, state == PBT_RUN,
                   dat_timer != '0, clk_timer != '0,
                   term_sat, term_man, term_errs,
                   term_bits, active};

  always_comb begin
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_CTRL:   rd_data = {{(32-CTRL_W){1'b0}}, ctrl};
      ADDR_CMD:    rd_data = '0;
      ADDR_STATUS: rd_data = {{(32-ST_W){1'b0}}, status};
      ADDR_BITS:   rd_data = bits;
      ADDR_ERRS:   rd_data = errs;
      ADDR_MAXB:   rd_data = max_bits;
      ADDR_MAXE:   rd_data = max_errs;
      ADDR_RBITS:  rd_data = res_bits;
      ADDR_RERRS:  rd_data = res_errs;
      default: begin
        rd_data = '0;
        rd_hit  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  pbt_link_sampler u_sampler (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .slope_neg    (ctrl[CTRL_NEG]),
    .link_clk     (link_clk),
    .link_data    (link_data),
    .link_de      (link_de),
    .link_restart (link_restart),
    .bit_stb      (bit_stb),
    .bit_data     (bit_data),
    .bit_de       (bit_de),
    .bit_restart  (bit_restart),
    .clk_edge     (clk_edge),
    .data_edge    (data_edge)
  );

  // Masking inputs only act when enabled; both off is plain mode
  assign rx      = bit_data ^ ctrl[CTRL_INV];
  assign bit_use = bit_stb && (!ctrl[CTRL_DE_EN] || bit_de);
  assign bit_rst = ctrl[CTRL_RST_EN] && bit_restart;
  assign pred    = lfsr[PRBS_DEG-1] ^ lfsr[PRBS_TAP-1];
  assign active  = (state == PBT_FILL) || (state == PBT_RUN);

  // Stop decisions on each counted bit
  assign next_bits = bits + 32'h0000_0001;
  assign next_errs = errs + {31'h0, flt_err};
  assign hit_bits  = flt_stb && next_bits >= max_bits;
  assign hit_errs  = flt_stb && flt_err &&
                     next_errs >= max_errs;
  assign hit_sat   = flt_stb && (next_bits == '1 ||
                                 next_errs == '1);
  assign stop  = active && (stop_pulse || hit_bits ||
                            hit_errs || hit_sat);
  assign start = ctrl[CTRL_EN] &&
                 ((state == PBT_IDLE &&
                   (!ctrl[CTRL_SINGLE] || exec_pulse)) ||
                  (state == PBT_DONE &&
                   (exec_pulse ||
                    (!ctrl[CTRL_SINGLE] && !term_man))));

  // Measurement sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_EN]) begin
      state    <= PBT_IDLE;
      fill_cnt <= '0;
      lfsr     <= '0;
      chk_stb  <= 1'b0;
      chk_bit  <= 1'b0;
      chk_err  <= 1'b0;
    end else begin
      chk_stb <= 1'b0;
      if (start) begin
        state    <= PBT_FILL;
        fill_cnt <= '0;
      end else if (stop) begin
        state <= PBT_DONE;
      end else if (active && bit_rst && bit_stb) begin
        state    <= PBT_FILL;
        fill_cnt <= '0;
      end else if (bit_use) begin
        unique case (state)
          PBT_FILL: begin
            lfsr     <= {lfsr[PRBS_DEG-2:0], rx};
            fill_cnt <= fill_cnt + FILL_W'(1);
            if (fill_cnt == FILL_W'(PRBS_DEG - 1))
              state <= PBT_RUN;
          end
          PBT_RUN: begin
            lfsr    <= {lfsr[PRBS_DEG-2:0], pred};
            chk_stb <= 1'b1;
            chk_bit <= rx;
            chk_err <= rx ^ pred;
          end
          PBT_IDLE, PBT_DONE: ;
        endcase
      end
    end
  end

  pbt_run_filter u_filter (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (start),
    .ignore_en (ctrl[CTRL_IGNORE]),
    .in_stb    (chk_stb),
    .in_bit    (chk_bit),
    .in_err    (chk_err),
    .out_stb   (flt_stb),
    .out_err   (flt_err)
  );

  // Counters survive restarts; cleared only when a measurement starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bits <= '0;
      errs <= '0;
    end else if (start) begin
      bits <= '0;
      errs <= '0;
    end else if (active && flt_stb) begin
      bits <= next_bits;
      errs <= next_errs;
    end
  end

  // Cause of the last stop and the finished result pair
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_EN]) begin
      term_bits <= 1'b0;
      term_errs <= 1'b0;
      term_man  <= 1'b0;
      term_sat  <= 1'b0;
      res_bits  <= '0;
      res_errs  <= '0;
    end else if (stop) begin
      term_bits <= hit_bits;
      term_errs <= hit_errs;
      term_man  <= stop_pulse;
      term_sat  <= hit_sat;
      // Latched as one pair so software divides consistent figures
      res_bits  <= flt_stb ? next_bits : bits;
      res_errs  <= flt_stb ? next_errs : errs;
    end
  end

  // Activity watchdogs on the link clock and data pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_timer <= '0;
      dat_timer <= '0;
    end else begin
      if (clk_edge)
        clk_timer <= ACT_W'(ACT_CYCLES);
      else if (clk_timer != '0)
        clk_timer <= clk_timer - ACT_W'(1);
      if (data_edge)
        dat_timer <= ACT_W'(ACT_CYCLES);
      else if (dat_timer != '0)
        dat_timer <= dat_timer - ACT_W'(1);
    end
  end

endmodule

// >>> verification/pbt_error_rate_checker_chk.sv
// Register port checker for the error rate checker.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/1ps
module pbt_error_rate_checker_chk import pbt_pkg::*; (
  // Clock and reset
  input wire logic              aclk,
  input wire logic              aresetn,
  // AXI4-Lite
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_w_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // Taken pair is registered first, so the answer comes two edges later
  a_b_answer: assert property (s_w_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_r_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read data late");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_ar_back: assert property (s_axi_rvalid && s_axi_rready |->
    ##[1:3] s_axi_arready) else $error("read port stuck");
  a_rd_unmapped: assert property (s_ar_take ##0 s_axi_araddr > ADDR_RERRS
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Reset itself is watched, so this one must not be disabled by it
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid && !s_axi_arready)
    else $error("bus active in reset");
endmodule
bind pbt_error_rate_checker pbt_error_rate_checker_chk u_chk (.*);

// >>> verification/pbt_dut_model.sv
// Device under test model: returns the ninth degree sequence with
// its bit clock; every fifth bit is a non-payload slot.
// Assumes the bench frames traffic with run.
`timescale 1ns/1ps
module pbt_dut_model (
  // Control from the bench
  input  wire logic       run,
  input  wire logic [7:0] err_e,
  // Link pins
  output logic            link_clk,
  output logic            link_data,
  output logic            link_de,
  output logic            link_restart
);
  logic [8:0] s = 9'h1ff;
  int         idx, n;
  bit         fl;
  initial begin
    link_clk = 0;
    link_de = 0;
    link_data = 0;
    link_restart = 0;
    #7;
    forever begin
      if (!run) begin
        // Clock stands still; data toggles so no stale level survives
        idx = 0;
        link_data = !link_data;
        #10;
      end else begin
        n++;
        link_de = n % 5 != 0;
        if (link_de) begin
          s = {s[7:0], s[8] ^ s[4]};
          fl = err_e != 0 && idx >= err_e && idx % err_e == 0;
          link_data = s[0] ^ fl;
          idx++;
        end else link_data = !link_data;
        #80 link_clk = 1;
        #80 link_clk = 0;
      end
    end
  end
endmodule

// >>> verification/pbt_error_rate_checker_tb.sv
// Bench: register reset values, bit limit, error limit, manual stop.
// Assumes the link model owns all link pins.
`timescale 1ns/1ps
module pbt_error_rate_checker_tb import pbt_pkg::*;;
  logic              aclk, aresetn, run;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, got;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic              s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic              s_axi_rready, link_clk, link_data, link_de;
  logic              link_restart;
  logic [7:0]        err_e;
  int                bad_count = 0, cmp_count = 0, cyc = 0, seed;
  pbt_error_rate_checker u_pbt_error_rate_checker (.*);
  pbt_dut_model u_pbt_dut_model (.*);
  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task complete_run;
    if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bit ad = 0, wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      ad |= s_axi_awready;
      wd |= s_axi_wready;
      s_axi_awvalid <= !ad;
      s_axi_wvalid <= !wd;
    end
    while (s_axi_bvalid !== 1) @(posedge aclk);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // Model: counted bit c is link payload bit c+8, after 9 fill bits
  task automatic meas(input logic [31:0] mb, me, input logic [7:0] ee,
                      input bit man);
    int c = 0, ne = 0;
    wr(ADDR_MAXB, mb);
    wr(ADDR_MAXE, me);
    wr(ADDR_CMD, 32'h1 << CMD_EXEC);
    err_e <= ee;
    run <= 1;
    if (man) begin
      repeat (400) @(posedge aclk);
      wr(ADDR_CMD, 32'h1 << CMD_STOP);
    end
    got = 0;
    while (got[ST_DONE] !== 1) rd(ADDR_STATUS);
    run <= 0;
    do begin
      c++;
      if (ee != 0 && (c + 8) % ee == 0) ne++;
    end while (c < mb && ne < me);
    chk(32'(got[ST_T_MAN]), 32'(man));
    if (!man) begin
      chk(32'(got[ST_T_BITS]), 32'(c >= mb));
      chk(32'(got[ST_T_ERRS]), 32'(ne >= me));
      rd(ADDR_BITS);
      chk(got, 32'(c));
      rd(ADDR_ERRS);
      chk(got, 32'(ne));
      rd(ADDR_RBITS);
      chk(got, 32'(c));
      rd(ADDR_RERRS);
      chk(got, 32'(ne));
    end
  endtask
  initial begin
    seed = 32'hd734;
    aresetn = 0;
    run = 0;
    err_e = 0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_CTRL);
    chk(got, 32'h0);
    rd(ADDR_MAXB);
    chk(got, MAXB_RESET);
    rd(ADDR_MAXE);
    chk(got, MAXE_RESET);
    rd(8'h40);
    chk(32'(resp), 32'(RESP_SLVERR));
    wr(8'h40, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    // Enable, single shot, data enable honoured
    wr(ADDR_CTRL, 32'h0b);
    rd(ADDR_CTRL);
    chk(got, 32'h0b);
    meas(32'd60 + 32'($random(seed) & 31), 32'd1000, 8'd0, 0);
    meas(32'd1000, 32'd3, 8'd20, 0);
    meas(32'd4000, 32'd1000, 8'd0, 1);
    complete_run();
  end
endmodule
